// ==== logic/uart_pair_aux_map.svh ====
// Purpose: register offsets, fields and reset values of the aux block
// Assumes: word-aligned AHB-Lite addresses, one register per word
// Notes: offsets are byte addresses within the block
`ifndef UART_PAIR_AUX_MAP_SVH
`define UART_PAIR_AUX_MAP_SVH
// register byte offsets
`define OFS_AUX_CTRL 8'h00
`define OFS_IN_CHANGE 8'h04
`define OFS_INT_STATUS 8'h08
`define OFS_INT_MASK 8'h0c
`define OFS_CNT_UPPER 8'h10
`define OFS_CNT_LOWER 8'h14
`define OFS_COMMAND 8'h18
`define OFS_CONFIG 8'h1c
// reset values
`define RST_AUX_CTRL 8'h00
`define RST_INT_MASK 8'h00
`define RST_PRESET 16'h0002
// auxiliary_control fields
`define ACR_BAUD_SET 7
`define ACR_MODE_HI 6
`define ACR_MODE_LO 4
// mode codes of acr[6:4]
`define MODE_CNT_PIN 3'h0
`define MODE_CNT_PIN16 3'h1
`define MODE_CNT_TXC 3'h2
`define MODE_CNT_OSC16 3'h3
`define MODE_TMR_PIN 3'h4
`define MODE_TMR_PIN16 3'h5
`define MODE_TMR_OSC 3'h6
`define MODE_TMR_OSC16 3'h7
// command bits
`define CMD_START 0
`define CMD_STOP 1
`define CMD_BRK_A 2
`define CMD_BRK_B 3
// interrupt_status bit positions
`define ISR_IN_CHANGE 7
`define ISR_COUNTER 3
// prescaler terminal value for divide by 16
`define DIV16_LAST 4'hf
`endif

// ==== logic/uart_pair_aux_pkg.sv ====
// Purpose: types of the uart pair auxiliary block
// Assumes: nothing
// Notes: holds the bus state enum and the block state struct
package uart_pair_aux_pkg;
   // bus slave states, gray along idle -> wait
   typedef enum logic [0:0] {BUS_IDLE = 1'b0, BUS_WAIT = 1'b1} bus_st_t;
   // whole block state
   typedef struct packed {
      bus_st_t bus;
      logic [2:0] addr;
      logic wr;
      logic hready;
      logic [31:0] rdata;
      logic [7:0] auxiliary_control;
      logic [7:0] interrupt_mask;
      logic [7:0] interrupt_status;
      logic [3:0] flags;
      logic [15:0] preset;
      logic [15:0] count;
      logic ct_run;
      logic ct_out;
      logic [3:0] pre16;
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic [4:0] prev;
      logic mpo_sel;
      logic intr_n;
      logic multi_output_pin;
   } aux_state_t;
endpackage

// ==== logic/uart_pair_aux.sv ====
// Purpose: shared aux logic of a uart channel pair (baud set, counter/
//   timer, input change detect, interrupt status and mask)
// Assumes: channel logic on mclk_in supplies receiver/transmitter events
// Notes: every bus transfer takes one wait state
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "uart_pair_aux_map.svh"
module uart_pair_aux (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic hready_in,
   input wire logic [31:0] hwdata_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [3:0] multi_inputs_in,
   input wire logic transmit_bit_clock_in,
   input wire logic [1:0] break_change_in,
   input wire logic [1:0] rx_push_in,
   input wire logic [1:0] rx_pop_in,
   input wire logic [3:0] rx_fifo_count_in,
   input wire logic [1:0] rx_shift_wait_in,
   input wire logic [1:0] rx_fifo_full_mode_in,
   input wire logic [1:0] transmit_holding_empty_in,
   output logic interrupt_out_n,
   output logic multi_output_pin_out,
   output logic baud_set_out
);
   uart_pair_aux_pkg::aux_state_t st; // registered state
   uart_pair_aux_pkg::aux_state_t nx; // next state
   logic [2:0] mode; // counter/timer mode field
   logic timer_mode; // high in timer modes
   logic pin_rise; // first input rising edge
   logic txc_rise; // transmit clock rising edge
   logic base_ev; // event feeding the div-16 prescaler
   logic tick; // counter/timer clock enable pulse
   logic rd_done; // read completing this cycle
   logic wr_done; // write completing this cycle
   logic [7:0] cmd; // command byte written now
   logic [3:0] pin_chg; // change seen on each input

   assign mode = st.auxiliary_control[`ACR_MODE_HI:`ACR_MODE_LO];
   assign timer_mode = mode[2];
   // edges come from synchronised levels only
   assign pin_rise = st.sync2[0] & ~st.prev[0];
   assign txc_rise = st.sync2[4] & ~st.prev[4];
   assign pin_chg = st.sync2[3:0] ^ st.prev[3:0];
   assign rd_done = (st.bus == uart_pair_aux_pkg::BUS_WAIT) & ~st.wr;
   assign wr_done = (st.bus == uart_pair_aux_pkg::BUS_WAIT) & st.wr;
   assign cmd = (wr_done && {st.addr, 2'b00} == 5'(`OFS_COMMAND)) ?
                hwdata_in[7:0] : 8'h00;

   // clock source selection for the counter/timer
   always_comb
   begin
      base_ev = 1'b0;
      tick = 1'b0;
      case (mode)
         `MODE_CNT_PIN, `MODE_TMR_PIN:
         begin
            tick = pin_rise;
         end
         `MODE_CNT_PIN16, `MODE_TMR_PIN16:
         begin
            base_ev = pin_rise;
            tick = pin_rise && st.pre16 == `DIV16_LAST;
         end
         `MODE_CNT_TXC:
         begin
            tick = txc_rise;
         end
         `MODE_TMR_OSC:
         begin
            tick = 1'b1;
         end
         default:
         begin
            // both oscillator divided by 16 codes
            base_ev = 1'b1;
            tick = st.pre16 == `DIV16_LAST;
         end
      endcase
   end

   // next-state logic of the whole block
   always_comb
   begin
      nx = st;
      // two-stage synchronisers, then edge history
      nx.sync1 = {transmit_bit_clock_in, multi_inputs_in};
      nx.sync2 = st.sync1;
      nx.prev = st.sync2;
      if (base_ev)
      begin
         nx.pre16 = st.pre16 + 4'h1;
      end
      // bus address phase capture
      nx.hready = 1'b1;
      nx.bus = uart_pair_aux_pkg::BUS_IDLE;
      if (st.bus == uart_pair_aux_pkg::BUS_IDLE && hsel_in &&
          htrans_in[1] && hready_in)
      begin
         // only whole-word transfers are expected; hsize unused
         nx.bus = uart_pair_aux_pkg::BUS_WAIT;
         nx.addr = haddr_in[4:2];
         nx.wr = hwrite_in;
         nx.hready = 1'b0; // one wait state to register read data
      end
      // register writes in the data phase
      if (wr_done)
      begin
         case ({st.addr, 2'b00})
            5'(`OFS_AUX_CTRL): nx.auxiliary_control = hwdata_in[7:0];
            5'(`OFS_INT_MASK): nx.interrupt_mask = hwdata_in[7:0];
            5'(`OFS_CNT_UPPER): nx.preset[15:8] = hwdata_in[7:0];
            5'(`OFS_CNT_LOWER): nx.preset[7:0] = hwdata_in[7:0];
            5'(`OFS_CONFIG): nx.mpo_sel = hwdata_in[0];
            default: nx.mpo_sel = st.mpo_sel; // command has no storage
         endcase
      end
      // register reads; reserved bits read zero
      nx.rdata = 32'h0000_0000;
      if (rd_done)
      begin
         case ({st.addr, 2'b00})
            5'(`OFS_AUX_CTRL): nx.rdata[7:0] = st.auxiliary_control;
            5'(`OFS_IN_CHANGE):
               nx.rdata[7:0] = {st.flags, st.sync2[3:0]};
            5'(`OFS_INT_STATUS): nx.rdata[7:0] = st.interrupt_status;
            5'(`OFS_INT_MASK): nx.rdata[7:0] = st.interrupt_mask;
            // running count in counter mode, else the loaded value
            5'(`OFS_CNT_UPPER):
               nx.rdata[7:0] = timer_mode ? st.preset[15:8] : st.count[15:8];
            5'(`OFS_CNT_LOWER):
               nx.rdata[7:0] = timer_mode ? st.preset[7:0] : st.count[7:0];
            5'(`OFS_CONFIG): nx.rdata[0] = st.mpo_sel;
            default: nx.rdata = 32'h0000_0000; // command reads zero
         endcase
      end
      // change flags: the read clears, a new change wins
      if (rd_done && {st.addr, 2'b00} == 5'(`OFS_IN_CHANGE))
      begin
         nx.flags = 4'h0;
         nx.interrupt_status[`ISR_IN_CHANGE] = 1'b0;
      end
      nx.flags = nx.flags | pin_chg;
      if (|(pin_chg & st.auxiliary_control[3:0]))
      begin
         nx.interrupt_status[`ISR_IN_CHANGE] = 1'b1;
      end
      // per-channel status bits, channel a low, channel b high
      for (int i = 0; i < 2; i++)
      begin
         // break change: command clears, detection wins
         if (cmd[`CMD_BRK_A + i])
         begin
            nx.interrupt_status[2 + 4 * i] = 1'b0;
         end
         if (break_change_in[i])
         begin
            nx.interrupt_status[2 + 4 * i] = 1'b1;
         end
         nx.interrupt_status[4 * i] = transmit_holding_empty_in[i];
         if (!rx_fifo_full_mode_in[i])
         begin
            // receiver ready: count is the level after this event
            if (rx_pop_in[i])
            begin
               nx.interrupt_status[1 + 4 * i] = |rx_fifo_count_in[2 * i +: 2];
            end
            if (rx_push_in[i])
            begin
               nx.interrupt_status[1 + 4 * i] = 1'b1;
            end
         end
         else
         begin
            // fifo full: a waiting character keeps the bit up
            if (rx_pop_in[i] && !rx_shift_wait_in[i])
            begin
               nx.interrupt_status[1 + 4 * i] = 1'b0;
            end
            if (rx_push_in[i] && rx_fifo_count_in[2 * i +: 2] == 2'h3)
            begin
               nx.interrupt_status[1 + 4 * i] = 1'b1;
            end
         end
      end
      // counter/timer commands
      if (cmd[`CMD_STOP])
      begin
         nx.interrupt_status[`ISR_COUNTER] = 1'b0;
         if (!timer_mode)
         begin
            nx.ct_run = 1'b0;
            nx.ct_out = 1'b1;
         end
      end
      if (cmd[`CMD_START])
      begin
         // fresh cycle from the held registers
         nx.count = st.preset;
         nx.ct_out = 1'b1;
         nx.ct_run = 1'b1;
      end
      else if (timer_mode && tick)
      begin
         // timer runs free; each half lasts preset ticks
         if (st.count <= 16'h0001)
         begin
            nx.count = st.preset;
            nx.ct_out = ~st.ct_out;
            if (!st.ct_out)
            begin
               nx.interrupt_status[`ISR_COUNTER] = 1'b1;
            end
         end
         else
         begin
            nx.count = st.count - 16'h0001;
         end
      end
      else if (!timer_mode && st.ct_run && tick)
      begin
         // 0 minus 1 wraps to ffff and keeps going
         nx.count = st.count - 16'h0001;
         if (st.count == 16'h0001)
         begin
            nx.interrupt_status[`ISR_COUNTER] = 1'b1;
            nx.ct_out = 1'b0;
         end
      end
      // outputs, all registered
      nx.intr_n = ~|(nx.interrupt_status & nx.interrupt_mask);
      nx.multi_output_pin = nx.mpo_sel ? nx.ct_out : 1'b1;
   end

   // state register with synchronous reset
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         st <= '0;
         st.bus <= uart_pair_aux_pkg::BUS_IDLE;
         st.hready <= 1'b1;
         st.auxiliary_control <= `RST_AUX_CTRL;
         st.interrupt_mask <= `RST_INT_MASK;
         st.preset <= `RST_PRESET;
         st.ct_out <= 1'b1;
         st.intr_n <= 1'b1;
         st.multi_output_pin <= 1'b1;
      end
      else
      begin
         st <= nx;
      end
   end

   assign hrdata_out = st.rdata;
   assign hreadyout_out = st.hready;
   assign hresp_out = 1'b0 & st.hready; // always okay
   assign interrupt_out_n = st.intr_n;
   assign multi_output_pin_out = st.multi_output_pin;
   assign baud_set_out = st.auxiliary_control[`ACR_BAUD_SET];

   // checks on the logic above; one clock, reset disables all
   AST_INTR_LEVEL: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      interrupt_out_n == ~|(st.interrupt_status & st.interrupt_mask))
      else $error("interrupt output disagrees with status and mask");
   // judged against the bus data, not against the state copy
   AST_BAUD_SET: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (wr_done && st.addr == 3'h0) |=> baud_set_out == $past(hwdata_in[7]))
      else $error("baud set output not following control bit");
   AST_CHANGE_CLEAR: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (rd_done && st.addr == 3'h1 && pin_chg == 4'h0) |=>
      st.flags == 4'h0 && !st.interrupt_status[7])
      else $error("change register read did not clear flags");
   // a change on a disabled input must leave the status bit alone
   AST_CHANGE_GATE: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (!st.interrupt_status[7] && (pin_chg & st.auxiliary_control[3:0]) == 4'h0) |=> !st.interrupt_status[7])
      else $error("disabled input change reached status");
   AST_BREAK_HOLD: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (st.interrupt_status[2] && !cmd[`CMD_BRK_A]) |=> st.interrupt_status[2])
      else $error("break change bit dropped without command");
   AST_TX_MIRROR: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ##1 st.interrupt_status[4] == $past(transmit_holding_empty_in[1]))
      else $error("transmitter ready bit not mirrored");
   AST_STATUS_READ: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (rd_done && st.addr == 3'h2) |=>
      hrdata_out == {24'h000000, $past(st.interrupt_status)} && hreadyout_out)
      else $error("status read returned wrong value");
   // a terminal tick in the same cycle wins over the stop
   AST_STOP_COUNTER: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (cmd[`CMD_STOP] && !cmd[`CMD_START] && !timer_mode &&
      !(st.ct_run && tick && st.count == 16'h0001)) |=>
      st.ct_out && !st.interrupt_status[3] && !st.ct_run)
      else $error("stop did not restore counter output");
   AST_TERMINAL: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (!timer_mode && st.ct_run && tick && st.count == 16'h0001 &&
      cmd == 8'h00) |=> st.interrupt_status[3] && !st.ct_out && st.count == 16'h0000)
      else $error("terminal count not flagged");
   AST_TIMER_HALF: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (timer_mode && tick && st.count == 16'h0001 && cmd == 8'h00) |=>
      st.count == $past(st.preset) && st.ct_out != $past(st.ct_out))
      else $error("timer half period did not reload and toggle");
   AST_WRAP: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (!timer_mode && st.ct_run && tick && st.count == 16'h0000 &&
      cmd == 8'h00) |=> st.count == 16'hffff)
      else $error("counter did not wrap to all ones");
   AST_MPO_FOLLOW: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      st.mpo_sel |-> multi_output_pin_out == st.ct_out)
      else $error("output pin not showing counter/timer output");
endmodule // uart_pair_aux

// ==== dv/uart_pair_aux_host.sv ====
// Purpose: host cpu model, an AHB-Lite master of single word transfers
// Assumes: one slave whose hreadyout is the bus hready
// Notes: xfer reports ok=0 when a wait runs past its bound
`timescale 1ns/1ps
module uart_pair_aux_host (
   input wire logic mclk_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_in,
   output logic hsel_out,
   output logic [31:0] haddr_out,
   output logic [1:0] htrans_out,
   output logic hwrite_out,
   output logic [2:0] hsize_out,
   output logic [31:0] hwdata_out
);
   // bus idle from time zero
   initial
   begin
      hsel_out = 1'b0;
      haddr_out = 32'h0;
      htrans_out = 2'h0;
      hwrite_out = 1'b0;
      hsize_out = 3'h2;
      hwdata_out = 32'h0;
   end

   // one transfer: address phase held until hready, then data phase
   task automatic xfer(input logic w, input logic [7:0] a, d,
      output logic [7:0] r, output bit ok);
      int n;
      n = 0;
      @(posedge mclk_in);
      hsel_out <= 1'b1;
      htrans_out <= 2'h2;
      haddr_out <= {24'h0, a};
      hwrite_out <= w;
      do @(posedge mclk_in); while (hready_in !== 1'b1 && ++n < 50);
      // an address phase never taken is a failed transfer
      ok = (n < 50);
      htrans_out <= 2'h0;
      hwdata_out <= {24'h0, d};
      do @(posedge mclk_in); while (hready_in !== 1'b1 && ++n < 100);
      // read data taken at the same edge as hready
      r = hrdata_in[7:0];
      ok = ok && (n < 100);
      // released bus shows no stale values
      hsel_out <= 1'b0;
      haddr_out <= ~{24'h0, a};
      hwdata_out <= ~{24'h0, d};
   endtask
endmodule // uart_pair_aux_host

// ==== dv/uart_pair_aux_tb.sv ====
// Purpose: self-checking bench of the uart pair aux block
// Assumes: host model drives the register bus
// Notes: one task per scenario, counter/timer on the oscillator
`timescale 1ns/1ps
`include "uart_pair_aux_map.svh"
module uart_pair_aux_tb;
   logic mclk, rst, transmit_bit_clock;
   logic [3:0] mi, fcnt;
   logic [1:0] brk, push, pop, swait, fmode, txe;
   logic hsel, hwrite, hrdy, hresp, int_n, multi_output_pin, baud;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int n_mismatch = 0, checks = 0, cyc = 0;

   // clock and cycle count
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) cyc <= cyc + 1;

   uart_pair_aux u_uart_pair_aux (.mclk_in(mclk), .rst_in(rst),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hrdy),
      .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hrdy),
      .hresp_out(hresp), .multi_inputs_in(mi),
      .transmit_bit_clock_in(transmit_bit_clock), .break_change_in(brk),
      .rx_push_in(push), .rx_pop_in(pop), .rx_fifo_count_in(fcnt),
      .rx_shift_wait_in(swait), .rx_fifo_full_mode_in(fmode),
      .transmit_holding_empty_in(txe), .interrupt_out_n(int_n),
      .multi_output_pin_out(multi_output_pin), .baud_set_out(baud));
   uart_pair_aux_host u_uart_pair_aux_host (.mclk_in(mclk),
      .hready_in(hrdy), .hrdata_in(hrdata), .hsel_out(hsel),
      .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
      .hsize_out(hsize), .hwdata_out(hwdata));

   task automatic chk(input logic [7:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // bus access; a hung bus ends the run
   task automatic rw(input logic w, input logic [7:0] a, d,
      output logic [7:0] r);
      bit ok;
      u_uart_pair_aux_host.xfer(w, a, d, r, ok);
      if (!ok)
      begin
         n_mismatch++;
         results();
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] r;
      rw(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [7:0] a, e);
      logic [7:0] r;
      rw(1'b0, a, 8'h00, r);
      chk(r, e);
   endtask
   // poll status until bit b sets, bounded
   task automatic poll(input int b);
      logic [7:0] r;
      int n;
      n = 0;
      do rw(1'b0, `OFS_INT_STATUS, 8'h00, r); while (!r[b] && ++n < 40);
      chk({7'h0, r[b]}, 8'h01);
      // a poll that runs out ends the run
      if (!r[b])
         results();
   endtask
   // one receiver event pulse, fifo level after it
   task automatic rxev(input logic [1:0] pu, po, input logic [3:0] c);
      @(posedge mclk);
      push <= pu;
      pop <= po;
      fcnt <= c;
      @(posedge mclk);
      push <= 2'h0;
      pop <= 2'h0;
   endtask

   task automatic t_reset();
      rdc(`OFS_AUX_CTRL, 8'h00);
      rdc(`OFS_INT_MASK, 8'h00);
      rdc(`OFS_INT_STATUS, 8'h00);
      chk({7'h0, int_n}, 8'h01);
      chk({7'h0, hresp}, 8'h00);
      $display("reset values done");
   endtask
   task automatic t_modes();
      for (int m = 0; m < 8; m++)
      begin
         wr(`OFS_AUX_CTRL, {m[0], m[2:0], 4'h0});
         rdc(`OFS_AUX_CTRL, {m[0], m[2:0], 4'h0});
         chk({7'h0, baud}, {7'h0, m[0]});
      end
      wr(`OFS_AUX_CTRL, 8'h00);
      // timer codes ran the timer and set bit 3; stop clears it
      wr(`OFS_COMMAND, 8'h02);
      rdc(`OFS_INT_STATUS, 8'h00);
      $display("mode codes done");
   endtask
   task automatic t_irq();
      txe <= 2'b11;
      repeat (3) @(posedge mclk);
      rdc(`OFS_INT_STATUS, 8'h11);
      chk({7'h0, int_n}, 8'h01);
      wr(`OFS_INT_MASK, 8'h01);
      chk({7'h0, int_n}, 8'h00);
      rdc(`OFS_INT_STATUS, 8'h11);
      txe <= 2'b00;
      repeat (3) @(posedge mclk);
      chk({7'h0, int_n}, 8'h01);
      $display("mask done");
   endtask
   task automatic t_break();
      @(posedge mclk);
      brk <= 2'b01;
      @(posedge mclk);
      brk <= 2'b00;
      rdc(`OFS_INT_STATUS, 8'h04);
      wr(`OFS_COMMAND, 8'h08);
      rdc(`OFS_INT_STATUS, 8'h04);
      wr(`OFS_COMMAND, 8'h04);
      rdc(`OFS_INT_STATUS, 8'h00);
      $display("break done");
   endtask
   task automatic t_rx();
      rxev(2'b01, 2'b00, 4'h1);
      rdc(`OFS_INT_STATUS, 8'h02);
      rxev(2'b00, 2'b01, 4'h1);
      rdc(`OFS_INT_STATUS, 8'h02);
      rxev(2'b00, 2'b01, 4'h0);
      rdc(`OFS_INT_STATUS, 8'h00);
      fmode <= 2'b01;
      rxev(2'b01, 2'b00, 4'h2);
      rdc(`OFS_INT_STATUS, 8'h00);
      rxev(2'b01, 2'b00, 4'h3);
      swait <= 2'b01;
      rxev(2'b00, 2'b01, 4'h2);
      rdc(`OFS_INT_STATUS, 8'h02);
      swait <= 2'b00;
      rxev(2'b00, 2'b01, 4'h1);
      rdc(`OFS_INT_STATUS, 8'h00);
      $display("receiver status done");
   endtask
   task automatic t_change();
      wr(`OFS_AUX_CTRL, 8'h01);
      mi <= 4'b0001;
      repeat (4) @(posedge mclk);
      rdc(`OFS_INT_STATUS, 8'h80);
      rdc(`OFS_IN_CHANGE, 8'h11);
      rdc(`OFS_INT_STATUS, 8'h00);
      mi <= 4'b0011;
      repeat (4) @(posedge mclk);
      rdc(`OFS_INT_STATUS, 8'h00);
      rdc(`OFS_IN_CHANGE, 8'h23);
      $display("input change done");
   endtask
   task automatic t_counter();
      int t0;
      wr(`OFS_CONFIG, 8'h01);
      wr(`OFS_CNT_UPPER, 8'h00);
      wr(`OFS_CNT_LOWER, 8'h03);
      wr(`OFS_AUX_CTRL, 8'h30);
      wr(`OFS_COMMAND, 8'h01);
      t0 = cyc;
      rdc(`OFS_INT_STATUS, 8'h00);
      chk({7'h0, multi_output_pin}, 8'h01);
      poll(3);
      chk({7'h0, (cyc - t0 >= 30 && cyc - t0 <= 62)}, 8'h01);
      chk({7'h0, multi_output_pin}, 8'h00);
      repeat (40) @(posedge mclk);
      // stop first so the upper count byte is read from a still counter
      wr(`OFS_COMMAND, 8'h02);
      chk({7'h0, multi_output_pin}, 8'h01);
      rdc(`OFS_INT_STATUS, 8'h00);
      rdc(`OFS_CNT_UPPER, 8'hff);
      $display("counter done");
   endtask
   task automatic t_timer();
      int tg;
      logic p;
      wr(`OFS_CNT_LOWER, 8'h04);
      wr(`OFS_AUX_CTRL, 8'h60);
      wr(`OFS_COMMAND, 8'h01);
      poll(3);
      wr(`OFS_COMMAND, 8'h02);
      tg = 0;
      p = multi_output_pin;
      repeat (16)
      begin
         @(posedge mclk);
         #1;
         if (multi_output_pin !== p) tg++;
         p = multi_output_pin;
      end
      chk(8'(tg), 8'h04);
      poll(3);
      $display("timer done");
   endtask

   // reset, then scenarios in turn
   initial
   begin
      rst = 1'b1;
      {transmit_bit_clock, mi, fcnt, brk, push, pop, swait, fmode, txe} = '0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_modes();
      t_irq();
      t_break();
      t_rx();
      t_change();
      t_counter();
      t_timer();
      results();
   end
endmodule // uart_pair_aux_tb
